/* rtl/crx_pkg.sv */
// Shared constants and carriers for the core reset, debug and exception controller.
// Assumes a single core clock domain; all users reference items as crx_pkg::name.
package crx_pkg;
    // ==========================================
    // Widths
    localparam int ADDR_W = 32;
    localparam int LEVEL_W = 6;
    localparam int RSET_W = 6;
    // ==========================================
    // Timing counts
    localparam int HOLD_PERIOD_NS = 800;
    localparam int CLOCK_NS = 50;
    localparam int HOLD_PERIOD_CYC = (HOLD_PERIOD_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int CNT_W = 8;
    // ==========================================
    // Default addresses (set at system generation)
    localparam logic [31:0] RESET_ADDR_DEF = 32'h0000_0000;
    localparam logic [31:0] EXC_ADDR_DEF = 32'h0000_0020;
    localparam logic [31:0] BREAK_ADDR_DEF = 32'h0000_0100;
    // ==========================================
    // Core control state
    typedef enum logic [2:0] {
        CRX_RUN = 3'h0,
        CRX_DRAIN = 3'h1,
        CRX_HOLD = 3'h2,
        CRX_HALT = 3'h3,
        CRX_EXC_DRAIN = 3'h4
    } crx_state_t;
    // External interrupt request carrier
    typedef struct packed {
        logic valid;
        logic nmi;
        logic [LEVEL_W-1:0] level;
        logic [RSET_W-1:0] rset;
        logic [ADDR_W-1:0] handler;
    } crx_xirq_t;
    // Redirect order to the fetch unit
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } crx_redir_t;
endpackage

/* rtl/crx_ctrl.sv */
// Reset, debug halt and precise exception control for a soft processor core.
// Assumes pipeline status inputs come from core logic on CLOCK; request pins are asynchronous.
`timescale 1ns/1ps
// ==========================================
module crx_ctrl #(
    parameter logic [31:0] RESET_ADDR = crx_pkg::RESET_ADDR_DEF,
    parameter logic [31:0] EXC_ADDR = crx_pkg::EXC_ADDR_DEF,
    parameter logic [31:0] BREAK_ADDR = crx_pkg::BREAK_ADDR_DEF,
    parameter int HOLD_PERIOD = crx_pkg::HOLD_PERIOD_CYC,
    parameter int NUM_IRQ = 32,
    parameter bit USE_XIRQ = 1'b0
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CPU_RESET_REQUEST,
    input wire logic DEBUG_REQUEST,
    input wire logic DEBUG_RELEASE,
    input wire logic DEBUG_STEP,
    input wire logic PIPE_EMPTY,
    input wire logic EXC_PENDING,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic [crx_pkg::LEVEL_W-1:0] CUR_LEVEL,
    input wire logic [NUM_IRQ-1:0] IRQ_IN,
    input wire logic [NUM_IRQ-1:0] IRQ_ENABLE,
    input wire crx_pkg::crx_xirq_t XIRQ_IN,
    input wire logic RESET_READ_DONE,
    output logic CPU_RESET_TAKEN,
    output logic DEBUG_ACK,
    output logic CORE_RESET,
    output logic STALL_ISSUE,
    output logic RESET_READ,
    output logic [31:0] RESET_READ_ADDR,
    output crx_pkg::crx_redir_t REDIRECT,
    output logic XIRQ_TAKEN,
    output logic [crx_pkg::RSET_W-1:0] XIRQ_RSET,
    output logic [NUM_IRQ-1:0] IRQ_TO_XIRQ
);
    // ==========================================
    // Elaboration checks
    if (HOLD_PERIOD < 2 || HOLD_PERIOD > 255)
    begin : gen_bad_hold
        $error("HOLD_PERIOD out of range");
    end
    if (NUM_IRQ < 1 || NUM_IRQ > 32)
    begin : gen_bad_irq
        $error("NUM_IRQ out of range");
    end
    // ==========================================
    // Synchronisers for asynchronous request pins
    logic [1:0] rr_sync_reg; // Local reset request sync chain
    logic [1:0] rr_sync_next;
    logic [1:0] dr_sync_reg; // Debug request sync chain
    logic [1:0] dr_sync_next;
    // Next values for the sync chains
    always_comb
    begin
        rr_sync_next = {rr_sync_reg[0], CPU_RESET_REQUEST};
        dr_sync_next = {dr_sync_reg[0], DEBUG_REQUEST};
    end

    // Sync chain registers
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            rr_sync_reg <= 2'h0;
            dr_sync_reg <= 2'h0;
        end
        else
        begin
            rr_sync_reg <= rr_sync_next;
            dr_sync_reg <= dr_sync_next;
        end
    end
    logic rst_req; // Synchronised local reset request
    logic dbg_req; // Synchronised debug request
    assign rst_req = rr_sync_reg[1];
    assign dbg_req = dr_sync_reg[1];
    // ==========================================
    // Interrupt qualification
    logic int_irq; // Internal controller request
    logic ext_irq; // External controller request accepted
    logic any_irq;
    // Decides whether an interrupt is to be serviced now
    always_comb
    begin
        int_irq = 1'b0;
        ext_irq = 1'b0;
        if (USE_XIRQ)
        begin
            // NMI requests are taken at once; others need GLOBAL_IRQ_ENABLE and a level above CUR_LEVEL
            if (XIRQ_IN.valid && XIRQ_IN.nmi)
                ext_irq = 1'b1;
            else if (XIRQ_IN.valid && GLOBAL_IRQ_ENABLE && XIRQ_IN.level > CUR_LEVEL)
                ext_irq = 1'b1;
        end
        else
        begin
            int_irq = GLOBAL_IRQ_ENABLE && |(IRQ_IN & IRQ_ENABLE);
        end
        any_irq = int_irq || ext_irq;
    end

    // ==========================================
    // Control state machine
    crx_pkg::crx_state_t state_reg; // Current control state
    crx_pkg::crx_state_t state_next;
    logic [crx_pkg::CNT_W-1:0] cnt_reg; // Hold period counter
    logic [crx_pkg::CNT_W-1:0] cnt_next;
    logic taken_reg; // Reset acknowledge pulse
    logic taken_next;
    logic dack_reg; // Debug acknowledge
    logic dack_next;
    logic core_rst_reg; // Core reset drive
    logic core_rst_next;
    logic stall_reg; // Issue stall
    logic stall_next;
    logic rd_reg; // Reset address read strobe
    logic rd_next;
    crx_pkg::crx_redir_t redir_reg; // Fetch redirect
    crx_pkg::crx_redir_t redir_next;
    logic xtaken_reg; // External interrupt accepted pulse
    logic xtaken_next;
    logic [crx_pkg::RSET_W-1:0] xrset_reg; // Register set for handler
    logic [crx_pkg::RSET_W-1:0] xrset_next;
    logic [31:0] exc_target_reg; // Latched exception target
    logic [31:0] exc_target_next;
    logic hold_tick;
    assign hold_tick = (cnt_reg == crx_pkg::CNT_W'(HOLD_PERIOD - 1));
    // Next-state and output computation
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        taken_next = 1'b0;
        dack_next = dack_reg;
        core_rst_next = core_rst_reg;
        stall_next = stall_reg;
        rd_next = 1'b0;
        redir_next = '0;
        xtaken_next = 1'b0;
        xrset_next = xrset_reg;
        exc_target_next = exc_target_reg;
        case (state_reg)
            crx_pkg::CRX_RUN:
            begin
                stall_next = 1'b0;
                core_rst_next = 1'b0; // Core leaves reset in its first running cycle
                if (rst_req)
                begin
                    // Stop issuing, let older instructions finish
                    stall_next = 1'b1;
                    state_next = crx_pkg::CRX_DRAIN;
                end
                else if (dbg_req)
                begin
                    // Halt as on a breakpoint
                    stall_next = 1'b1;
                    redir_next = '{valid: 1'b1, addr: BREAK_ADDR};
                    dack_next = 1'b1;
                    state_next = crx_pkg::CRX_HALT;
                end
                else if (EXC_PENDING || any_irq)
                begin
                    // Freeze younger instructions
                    stall_next = 1'b1;
                    if (ext_irq)
                    begin
                        exc_target_next = XIRQ_IN.handler;
                        xrset_next = XIRQ_IN.rset;
                        xtaken_next = 1'b1;
                    end
                    else
                        exc_target_next = EXC_ADDR;
                    state_next = crx_pkg::CRX_EXC_DRAIN;
                end
            end
            crx_pkg::CRX_EXC_DRAIN:
            begin
                // Redirect only when all older instructions completed
                if (PIPE_EMPTY)
                begin
                    redir_next = '{valid: 1'b1, addr: exc_target_reg};
                    stall_next = 1'b0;
                    state_next = crx_pkg::CRX_RUN;
                end
            end
            crx_pkg::CRX_DRAIN:
            begin
                if (!rst_req)
                begin
                    stall_next = 1'b0;
                    state_next = crx_pkg::CRX_RUN;
                end
                else if (PIPE_EMPTY)
                begin
                    core_rst_next = 1'b1;
                    taken_next = 1'b1;
                    rd_next = 1'b1;
                    cnt_next = '0;
                    state_next = crx_pkg::CRX_HOLD;
                end
            end
            crx_pkg::CRX_HOLD:
            begin
                if (!rst_req)
                begin
                    core_rst_next = 1'b0;
                    stall_next = 1'b0;
                    redir_next = '{valid: 1'b1, addr: RESET_ADDR};
                    state_next = crx_pkg::CRX_RUN;
                end
                else if (hold_tick)
                begin
                    cnt_next = '0;
                    taken_next = 1'b1;
                    rd_next = 1'b1;
                end
                else
                    cnt_next = cnt_reg + crx_pkg::CNT_W'(1);
            end
            crx_pkg::CRX_HALT:
            begin
                // Further debug requests ignored here; a pending local reset is taken on release or step
                if (DEBUG_RELEASE || DEBUG_STEP)
                begin
                    if (DEBUG_RELEASE)
                        dack_next = 1'b0;
                    if (rst_req)
                    begin
                        dack_next = 1'b0;
                        state_next = crx_pkg::CRX_DRAIN;
                    end
                    else if (DEBUG_RELEASE)
                    begin
                        stall_next = 1'b0;
                        state_next = crx_pkg::CRX_RUN;
                    end
                end
            end
            default:
            begin
                state_next = crx_pkg::CRX_RUN;
            end
        endcase
    end
    // Control registers; global reset acts on the very next edge
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            state_reg <= crx_pkg::CRX_RUN;
            cnt_reg <= '0;
            taken_reg <= 1'b0;
            dack_reg <= 1'b0;
            core_rst_reg <= 1'b1;
            stall_reg <= 1'b1;
            rd_reg <= 1'b0;
            redir_reg <= '0;
            xtaken_reg <= 1'b0;
            xrset_reg <= '0;
            exc_target_reg <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            taken_reg <= taken_next;
            dack_reg <= dack_next;
            core_rst_reg <= core_rst_next;
            stall_reg <= stall_next;
            rd_reg <= rd_next;
            redir_reg <= redir_next;
            xtaken_reg <= xtaken_next;
            xrset_reg <= xrset_next;
            exc_target_reg <= exc_target_next;
        end
    end
    // Routing and read address flops, so that every output leaves a register
    logic [NUM_IRQ-1:0] route_reg; // Sources routed to external controller
    logic [NUM_IRQ-1:0] route_next;
    logic [31:0] raddr_reg; // Address of the discarded reset read
    logic [31:0] raddr_next;
    // Routing and read address next values
    always_comb
    begin
        route_next = USE_XIRQ ? IRQ_IN : '0;
        raddr_next = RESET_ADDR;
    end
    // Routing and read address registers
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            route_reg <= '0;
            raddr_reg <= RESET_ADDR;
        end
        else
        begin
            route_reg <= route_next;
            raddr_reg <= raddr_next;
        end
    end
    // ==========================================
    // Outputs
    assign CPU_RESET_TAKEN = taken_reg;
    assign DEBUG_ACK = dack_reg;
    assign CORE_RESET = core_rst_reg;
    assign STALL_ISSUE = stall_reg;
    assign RESET_READ = rd_reg;
    assign RESET_READ_ADDR = raddr_reg;
    assign REDIRECT = redir_reg;
    assign XIRQ_TAKEN = xtaken_reg;
    assign XIRQ_RSET = xrset_reg;
    assign IRQ_TO_XIRQ = route_reg;
endmodule

/* tb/crx_ctrl_asserts.sv */
// Checker for the core reset, debug halt and exception controller.
// Assumes one core clock; bound to every crx_ctrl instance below.
`timescale 1ns/1ps
module crx_ctrl_asserts #(
    parameter int HOLD = 4,
    parameter int NUM_IRQ = 32,
    parameter logic [31:0] RESET_ADDR = 32'h0000_0000,
    parameter logic [31:0] EXC_ADDR = 32'h0000_0020,
    parameter logic [31:0] BREAK_ADDR = 32'h0000_0100
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CPU_RESET_REQUEST,
    input wire logic DEBUG_RELEASE,
    input wire logic DEBUG_STEP,
    input wire logic PIPE_EMPTY,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic [crx_pkg::LEVEL_W-1:0] CUR_LEVEL,
    input wire logic [NUM_IRQ-1:0] IRQ_IN,
    input wire crx_pkg::crx_xirq_t XIRQ_IN,
    input wire logic CPU_RESET_TAKEN,
    input wire logic DEBUG_ACK,
    input wire logic CORE_RESET,
    input wire logic STALL_ISSUE,
    input wire logic RESET_READ,
    input wire logic [31:0] RESET_READ_ADDR,
    input wire crx_pkg::crx_redir_t REDIRECT,
    input wire logic XIRQ_TAKEN,
    input wire logic [crx_pkg::RSET_W-1:0] XIRQ_RSET,
    input wire logic [NUM_IRQ-1:0] IRQ_TO_XIRQ
);
    // ==========================================
    // Clocking
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    // ==========================================
    // Reset and local reset
    AST_GLOBAL_RESET: assert property (disable iff (1'b0) RESET |=>
        CORE_RESET && STALL_ISSUE && !CPU_RESET_TAKEN && !DEBUG_ACK) else $error("reset late");
    AST_DRAIN_FIRST: assert property (CPU_RESET_TAKEN && !$past(CORE_RESET) |->
        $past(PIPE_EMPTY) && $past(STALL_ISSUE)) else $error("reset before drain");
    AST_TAKEN_ONE: assert property (CPU_RESET_TAKEN |=> !CPU_RESET_TAKEN)
        else $error("taken too long");
    AST_TAKEN_REPEAT: assert property (CPU_RESET_TAKEN ##1 CPU_RESET_REQUEST[*4]
        |-> ##[0:HOLD] CPU_RESET_TAKEN) else $error("taken not repeated");
    AST_READ_RESET: assert property (CPU_RESET_TAKEN |-> RESET_READ && CORE_RESET
        && RESET_READ_ADDR == RESET_ADDR) else $error("reset read wrong");
    AST_LEAVE_RESET: assert property ($fell(CPU_RESET_REQUEST) && CORE_RESET
        |-> ##[1:5] REDIRECT.valid && REDIRECT.addr == RESET_ADDR) else $error("no restart");
    // ==========================================
    // Debug halt
    AST_DEBUG_ENTRY: assert property ($rose(DEBUG_ACK) |-> REDIRECT.valid
        && REDIRECT.addr == BREAK_ADDR) else $error("halt not at break address");
    AST_DEBUG_STAYS: assert property (DEBUG_ACK && !DEBUG_RELEASE && !DEBUG_STEP
        |=> DEBUG_ACK) else $error("halt lost");
    AST_DEBUG_NO_RESET: assert property (DEBUG_ACK |-> !CORE_RESET && !CPU_RESET_TAKEN)
        else $error("reset while halted");
    // ==========================================
    // Exceptions and interrupts
    AST_EXC_PRECISE: assert property (REDIRECT.valid && REDIRECT.addr == EXC_ADDR
        |-> $past(PIPE_EMPTY) && $past(STALL_ISSUE)) else $error("exception not precise");
    AST_XIRQ_ACCEPT: assert property (XIRQ_TAKEN |-> $past(XIRQ_IN.valid) &&
        ($past(XIRQ_IN.nmi) || $past(GLOBAL_IRQ_ENABLE) && $past(XIRQ_IN.level) >
        $past(CUR_LEVEL))) else $error("interrupt taken wrongly");
    AST_XIRQ_RSET: assert property (XIRQ_TAKEN |-> XIRQ_RSET == $past(XIRQ_IN.rset))
        else $error("register set wrong");
    AST_IRQ_ROUTED: assert property (!$past(RESET) |-> IRQ_TO_XIRQ == $past(IRQ_IN))
        else $error("lines not routed out");
    COV_REPEAT: cover property (CPU_RESET_TAKEN ##HOLD CPU_RESET_TAKEN);
    COV_HALT: cover property ($rose(DEBUG_ACK));
    COV_NMI: cover property (XIRQ_TAKEN && $past(XIRQ_IN.nmi));
endmodule
bind crx_ctrl crx_ctrl_asserts #(.HOLD(HOLD_PERIOD), .NUM_IRQ(NUM_IRQ),
    .RESET_ADDR(RESET_ADDR), .EXC_ADDR(EXC_ADDR), .BREAK_ADDR(BREAK_ADDR)) crx_ctrl_asserts_i (
    .CLOCK(CLOCK), .RESET(RESET), .CPU_RESET_REQUEST(CPU_RESET_REQUEST),
    .DEBUG_RELEASE(DEBUG_RELEASE), .DEBUG_STEP(DEBUG_STEP), .PIPE_EMPTY(PIPE_EMPTY),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .CUR_LEVEL(CUR_LEVEL), .IRQ_IN(IRQ_IN),
    .XIRQ_IN(XIRQ_IN), .CPU_RESET_TAKEN(CPU_RESET_TAKEN), .DEBUG_ACK(DEBUG_ACK),
    .CORE_RESET(CORE_RESET), .STALL_ISSUE(STALL_ISSUE), .RESET_READ(RESET_READ),
    .RESET_READ_ADDR(RESET_READ_ADDR), .REDIRECT(REDIRECT), .XIRQ_TAKEN(XIRQ_TAKEN),
    .XIRQ_RSET(XIRQ_RSET), .IRQ_TO_XIRQ(IRQ_TO_XIRQ));

/* tb/crx_far.sv */
// Far side model: local reset requester and external interrupt controller.
// Assumes the bench sets its wishes at the falling edge of the core clock.
`timescale 1ns/1ps
module crx_far (
    input wire logic clk,
    input wire logic want_rst,
    input wire logic want_irq,
    input wire crx_pkg::crx_xirq_t irq_data,
    input wire logic taken,
    input wire logic irq_taken,
    output logic rst_req,
    output crx_pkg::crx_xirq_t irq_out
);
    logic seen_reg; // Acknowledge seen for the current request
    logic done_reg; // Interrupt accepted, stay withdrawn
    initial
    begin
        rst_req = 1'b0;
        irq_out = '0;
        seen_reg = 1'b0;
        done_reg = 1'b0;
    end
    // Request stays up until the acknowledge has been seen
    always @(negedge clk)
    begin
        seen_reg <= rst_req && (seen_reg || taken);
        rst_req <= want_rst || (rst_req && !seen_reg && !taken);
    end
    // One chosen request with handler, set and level; idle fields keep changing
    always @(negedge clk)
    begin
        done_reg <= want_irq && (done_reg || irq_taken);
        if (want_irq && !done_reg && !irq_taken)
            irq_out <= {1'b1, irq_data[44:0]};
        else
            irq_out <= {1'b0, ~irq_out[44:0]};
    end
endmodule

/* tb/crx_ctrl_tb.sv */
// Self-checking bench for the reset, debug and exception controller.
// Assumes crx_pkg, crx_ctrl, crx_far and the bound checker are compiled first.
`timescale 1ns/1ps
module crx_ctrl_tb;
    localparam int HP = 4; // Short hold period keeps the run brief
    logic clk = 1'b0, rst = 1'b1, dreq = 1'b0, drel = 1'b0, dstep = 1'b0, pipe = 1'b1;
    logic exc = 1'b0, gie = 1'b0, rd_done = 1'b0, want_rst = 1'b0, want_irq = 1'b0;
    logic mon_on = 1'b0, rreq, taken, dack, core_rst, stall, rread, xtaken, ok, hit;
    logic [5:0] cur = 6'h00, xrset;
    logic [31:0] irq_in = 32'h0, irq_en = 32'h0, raddr, irq_out;
    crx_pkg::crx_xirq_t xdata = '0, xin;
    crx_pkg::crx_redir_t redir;
    logic [31:0] exp_q[$];
    logic [5:0] rs_q[$];
    int err_count = 0, total_checks = 0, cyc = 0, n;
    crx_ctrl #(.HOLD_PERIOD(HP), .USE_XIRQ(1'b1)) crx_ctrl_i (
        .CLOCK(clk), .RESET(rst), .CPU_RESET_REQUEST(rreq), .DEBUG_REQUEST(dreq),
        .DEBUG_RELEASE(drel), .DEBUG_STEP(dstep), .PIPE_EMPTY(pipe), .EXC_PENDING(exc),
        .GLOBAL_IRQ_ENABLE(gie), .CUR_LEVEL(cur), .IRQ_IN(irq_in), .IRQ_ENABLE(irq_en),
        .XIRQ_IN(xin), .RESET_READ_DONE(rd_done), .CPU_RESET_TAKEN(taken), .DEBUG_ACK(dack),
        .CORE_RESET(core_rst), .STALL_ISSUE(stall), .RESET_READ(rread),
        .RESET_READ_ADDR(raddr), .REDIRECT(redir), .XIRQ_TAKEN(xtaken), .XIRQ_RSET(xrset),
        .IRQ_TO_XIRQ(irq_out));
    crx_far crx_far_i (.clk(clk), .want_rst(want_rst), .want_irq(want_irq),
        .irq_data(xdata), .taken(taken), .irq_taken(xtaken), .rst_req(rreq), .irq_out(xin));
    always #25 clk = ~clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Internal lines wander freely; read data comes back and is thrown away
    always @(negedge clk)
    begin
        if (mon_on)
            check("routed", irq_out, irq_in);
        irq_in <= $urandom();
        irq_en <= $urandom();
        rd_done <= rread;
    end
    // Each redirect or accepted interrupt is matched to the oldest note
    always @(negedge clk)
    begin
        if (mon_on && redir.valid)
            check("redirect", redir.addr, exp_q.size() ? exp_q.pop_front() : ~redir.addr);
        if (mon_on && xtaken)
            check("rset", 32'(xrset), rs_q.size() ? 32'(rs_q.pop_front()) : 32'hffff_ffff);
        if (mon_on && taken)
        begin
            check("reset read", 32'(rread), 32'h1);
            check("read addr", raddr, crx_pkg::RESET_ADDR_DEF);
        end
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            err_count++;
            finish_test();
        end
    end
    initial
    begin
        void'($urandom(32'h960c1fa3));
        repeat (4) @(negedge clk);
        check("core reset", 32'(core_rst & stall), 32'h1);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        mon_on = 1'b1;
        // Exception waits for a drained pipeline
        pipe = 1'b0;
        exc = 1'b1;
        exp_q.push_back(crx_pkg::EXC_ADDR_DEF);
        repeat (8) @(negedge clk);
        pipe = 1'b1;
        for (int i = 0; i < 20 && !redir.valid; i++)
            @(negedge clk);
        exc = 1'b0;
        // Local reset: plain, released by a single step, released by resume
        for (int k = 0; k < 3; k++)
        begin
            pipe = 1'b0;
            if (k > 0)
            begin
                exp_q.push_back(crx_pkg::BREAK_ADDR_DEF);
                dreq = 1'b1;
                for (int i = 0; i < 10 && !dack; i++)
                    @(negedge clk);
                dreq = 1'b0;
            end
            want_rst = 1'b1;
            repeat (8) @(negedge clk);
            dreq = (k > 0);
            repeat (4) @(negedge clk);
            check("core reset", 32'(core_rst), 32'h0);
            check("halted", 32'(dack), 32'(k > 0));
            check("stalled", 32'(stall), 32'h1);
            dreq = 1'b0;
            dstep = (k == 1);
            drel = (k == 2);
            @(negedge clk);
            dstep = 1'b0;
            drel = 1'b0;
            pipe = 1'b1;
            n = 0;
            repeat (24)
            begin
                @(negedge clk);
                n += taken;
            end
            check("taken pulses", 32'(n >= 4), 32'h1);
            check("held in reset", 32'(core_rst), 32'h1);
            want_rst = 1'b0;
            exp_q.push_back(crx_pkg::RESET_ADDR_DEF);
            repeat (8) @(negedge clk);
            check("core reset", 32'(core_rst), 32'h0);
            check("issuing", 32'(stall), 32'h0);
        end
        // External interrupts of random level, mask and kind
        for (int k = 0; k < 16; k++)
        begin
            gie = 1'($urandom());
            cur = 6'($urandom());
            xdata = 46'({$urandom(), $urandom()});
            xdata.nmi = ($urandom_range(0, 3) == 0);
            ok = xdata.nmi || (gie && xdata.level > cur);
            if (ok)
            begin
                exp_q.push_back(xdata.handler);
                rs_q.push_back(xdata.rset);
            end
            want_irq = 1'b1;
            hit = 1'b0;
            repeat (12)
            begin
                @(negedge clk);
                hit |= xtaken;
            end
            want_irq = 1'b0;
            check("irq accepted", 32'(hit), 32'(ok));
            repeat (12) @(negedge clk);
        end
        check("pending notes", 32'(exp_q.size() + rs_q.size()), 32'h0);
        // Global reset in mid-drain takes effect at once
        mon_on = 1'b0;
        exc = 1'b1;
        pipe = 1'b0;
        repeat (4) @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        check("core reset", 32'(core_rst), 32'h1);
        check("stall in reset", 32'(stall), 32'h1);
        finish_test();
    end
endmodule
